//--- src/ald_top.sv
// What this block does
// - quick load sign-extends byte to 32 bits
// - or opmodes pick size and destination
// - operand-space bit selects register or memory
// - memory mode: address registers, predecrement
// - subtract opmodes pick size and direction
// - address subtract: 011 word, 111 long
// - extend and memory compare size field
// - compare to data register sets flags only
// - compare to address register: 011/111 sizes
// - exclusive-or only has memory-destination opmodes
// - and opmodes pick size and destination
// - swap types: data, address, mixed
// - mixed swap: upper data, lower address
// - add opmodes pick size and destination
// - address add: 011 word, 111 long
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ald_defines.svh"
module ald_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_word,
    output logic fetch_ready,
    output logic dec_valid,
    output ald_pkg::ald_dec_t dec
);
    // registered state and its next value
    ald_pkg::ald_state_t s_reg;
    ald_pkg::ald_state_t s_next;
    // word handed to the decoder
    logic [15:0] dec_word;
    // decoder result for dec_word
    ald_pkg::ald_dec_t dec_out;
    // data-phase write to the opword register
    logic sw_wr;
    // data-phase write to the control register
    logic ctrl_wr;
    // a word is decoded this cycle
    logic take;

    // data-phase write decode
    assign sw_wr = s_reg.pend && s_reg.pwrite && s_reg.paddr == `ALD_OFS_OPWORD;
    assign ctrl_wr = s_reg.pend && s_reg.pwrite && s_reg.paddr == `ALD_OFS_CTRL;

    // prefetch port is held off while software injects a word
    assign fetch_ready = ce && s_reg.port_en && !sw_wr;

    // software word wins over the prefetch word
    assign dec_word = sw_wr ? hwdata[15:0] : fetch_word;

    // decoded when enabled and either software writes a word or a prefetch word is accepted
    assign take = ce && (sw_wr || (fetch_valid && fetch_ready));

    // the field decoder proper
    ald_field_decode u_dec (
        .word(dec_word),
        .dec(dec_out)
    );

    // readback of a register from a given state
    function automatic logic [31:0] rd_mux(
        input logic [7:0] a,
        input ald_pkg::ald_state_t st
    );
        case (a)
            `ALD_OFS_CTRL: rd_mux = {31'h0, st.port_en};
            `ALD_OFS_OPWORD: rd_mux = {16'h0, st.opword};
            `ALD_OFS_RESULT: rd_mux = {11'h0, st.dec.res};
            `ALD_OFS_IMMED: rd_mux = st.dec.imm;
            default: rd_mux = 32'h0;
        endcase
    endfunction

    // next-state logic: writes, decode, then address phase
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            // decode strobe lasts one enabled cycle
            s_next.dec_valid = 1'b0;
            // control register write
            if (ctrl_wr) begin
                s_next.port_en = hwdata[`ALD_CTRL_PORT_EN_BIT];
            end
            // capture the decoded word and its fields
            if (take) begin
                s_next.opword = dec_word;
                s_next.dec = dec_out;
                s_next.dec_valid = 1'b1;
            end
            // address phase is sampled only with hready high
            s_next.pend = hsel && hready && htrans[1];
            s_next.pwrite = hwrite;
            s_next.paddr = haddr[7:0];
            // read data taken from the updated state, so a read
            // right after a write sees the written value
            if (hsel && hready && htrans[1] && !hwrite) begin
                s_next.hrdata = rd_mux(haddr[7:0], s_next);
            end
        end
    end

    // state register, constants only under reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.port_en <= `ALD_CTRL_PORT_EN_RST;
            s_reg.opword <= `ALD_OPWORD_RST;
            s_reg.dec.res.size <= ald_pkg::sz_none;
        end else begin
            s_reg <= s_next;
        end
    end

    // bus outputs: stall only while the clock enable is low
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = s_reg.hrdata;

    // decoded outputs come from the state register
    assign dec_valid = s_reg.dec_valid;
    assign dec = s_reg.dec;

    // checks on the registered decode against the captured word
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // fields of the captured word
    logic [3:0] q_line;
    logic [2:0] q_opm;
    logic [4:0] q_xtype;
    assign q_line = s_reg.opword[15:12];
    assign q_opm = s_reg.opword[8:6];
    assign q_xtype = s_reg.opword[7:3];

    // quick load carries the sign-extended byte
    chk_quick_sign_ext: assert property (
        dec_valid && q_line == `ALD_LINE_QUICK && !s_reg.opword[8]
        |-> dec.res.op == ald_pkg::op_quick_immediate_load
            && dec.imm == {{24{s_reg.opword[7]}}, s_reg.opword[7:0]}
            && dec.res.size == ald_pkg::sz_long
    ) else $error("quick load immediate not sign extended");

    // or sizes and destination
    chk_or_sizes: assert property (
        dec_valid && q_line == `ALD_LINE_OR && q_opm[1:0] != `ALD_OPM_ADDR
            && s_reg.opword[8:4] != `ALD_DECIMAL_PAT
        |-> dec.res.op == ald_pkg::op_or && 2'(dec.res.size) == q_opm[1:0]
            && dec.res.ea_dest == q_opm[2]
    ) else $error("or opmode decoded wrongly");

    // extended and decimal forms follow the operand-space bit
    chk_ext_space: assert property (
        dec_valid && (dec.res.op == ald_pkg::op_add_with_extend
            || dec.res.op == ald_pkg::op_subtract_with_extend
            || dec.res.op == ald_pkg::op_decimal_add
            || dec.res.op == ald_pkg::op_decimal_subtract)
        |-> dec.res.mem_mode == s_reg.opword[3]
    ) else $error("operand space bit ignored");

    // register kinds follow the mode
    chk_ext_regkind: assert property (
        dec_valid && dec.res.legal && dec.res.mem_mode && !dec.res.postinc
        |-> dec.res.rx_addr && dec.res.ry_addr && dec.res.predec
    ) else $error("memory mode registers not predecrement address");

    // subtract sizes and direction
    chk_sub_dir: assert property (
        dec_valid && q_line == `ALD_LINE_SUB && q_opm[1:0] != `ALD_OPM_ADDR
            && !(s_reg.opword[8] && s_reg.opword[5:4] == 2'h0)
        |-> dec.res.op == ald_pkg::op_sub && 2'(dec.res.size) == q_opm[1:0]
            && dec.res.ea_dest == q_opm[2]
    ) else $error("subtract opmode decoded wrongly");

    // address subtract sizes
    chk_addr_sub: assert property (
        dec_valid && q_line == `ALD_LINE_SUB && q_opm[1:0] == `ALD_OPM_ADDR
        |-> dec.res.op == ald_pkg::op_address_subtract && dec.res.rx_addr
            && dec.res.size == (q_opm[2] ? ald_pkg::sz_long : ald_pkg::sz_word)
    ) else $error("address subtract size wrong");

    // size field of extended and memory compare forms
    chk_ext_size: assert property (
        dec_valid && (dec.res.op == ald_pkg::op_add_with_extend
            || dec.res.op == ald_pkg::op_subtract_with_extend
            || dec.res.op == ald_pkg::op_memory_compare_postinc)
        |-> 2'(dec.res.size) == s_reg.opword[7:6]
    ) else $error("extend size field wrong");

    // compares write nothing, only flags
    chk_cmp_flags: assert property (
        dec_valid && q_line == `ALD_LINE_CMP && !s_reg.opword[8]
            && q_opm[1:0] != `ALD_OPM_ADDR
        |-> dec.res.op == ald_pkg::op_cmp && dec.res.flags_only
            && !dec.res.ea_dest && 2'(dec.res.size) == q_opm[1:0]
    ) else $error("compare to data register decoded wrongly");

    // compare to address register
    chk_addr_cmp: assert property (
        dec_valid && q_line == `ALD_LINE_CMP && q_opm[1:0] == `ALD_OPM_ADDR
        |-> dec.res.op == ald_pkg::op_address_cmp && dec.res.flags_only
            && dec.res.size == (q_opm[2] ? ald_pkg::sz_long : ald_pkg::sz_word)
    ) else $error("compare to address register decoded wrongly");

    // exclusive-or only writes the effective address
    chk_xor_dest: assert property (
        dec_valid && dec.res.op == ald_pkg::op_exclusive_or
        |-> q_opm[2] && dec.res.ea_dest && !dec.res.flags_only
            && 2'(dec.res.size) == q_opm[1:0]
    ) else $error("exclusive-or decoded wrongly");

    // and sizes and destination
    chk_and_sizes: assert property (
        dec_valid && dec.res.op == ald_pkg::op_and
        |-> q_line == `ALD_LINE_AND && q_opm[1:0] != `ALD_OPM_ADDR
            && 2'(dec.res.size) == q_opm[1:0] && dec.res.ea_dest == q_opm[2]
    ) else $error("and opmode decoded wrongly");

    // swap types and register kinds
    chk_swap_types: assert property (
        dec_valid && dec.res.op == ald_pkg::op_register_swap
        |-> (q_xtype == `ALD_SWAP_DATA && !dec.res.rx_addr && !dec.res.ry_addr)
            || (q_xtype == `ALD_SWAP_ADDR && dec.res.rx_addr && dec.res.ry_addr)
            || (q_xtype == `ALD_SWAP_MIXED && !dec.res.rx_addr && dec.res.ry_addr)
    ) else $error("swap type decoded wrongly");

    // mixed swap takes the upper field as data register
    chk_swap_mixed: assert property (
        dec_valid && q_line == `ALD_LINE_AND && q_xtype == `ALD_SWAP_MIXED
            && s_reg.opword[8]
        |-> dec.res.op == ald_pkg::op_register_swap
            && dec.res.rx == s_reg.opword[11:9] && dec.res.ry == s_reg.opword[2:0]
    ) else $error("mixed swap registers wrong");

    // add sizes and destination
    chk_add_dir: assert property (
        dec_valid && dec.res.op == ald_pkg::op_add
        |-> 2'(dec.res.size) == q_opm[1:0] && dec.res.ea_dest == q_opm[2]
    ) else $error("add opmode decoded wrongly");

    // address add sizes
    chk_addr_add: assert property (
        dec_valid && q_line == `ALD_LINE_ADD && q_opm[1:0] == `ALD_OPM_ADDR
        |-> dec.res.op == ald_pkg::op_address_add && !dec.res.flags_only
            && dec.res.size == (q_opm[2] ? ald_pkg::sz_long : ald_pkg::sz_word)
    ) else $error("address add size wrong");

    // unlisted codes stay out of this group
    chk_unlisted: assert property (
        dec_valid && ((q_line == `ALD_LINE_OR && q_opm[1:0] == `ALD_OPM_ADDR)
            || (q_line == `ALD_LINE_QUICK && s_reg.opword[8]))
        |-> !dec.res.legal && dec.res.op == ald_pkg::op_none
    ) else $error("unlisted code decoded as an instruction");

    // a software word shows up decoded one enabled edge later
    chk_sw_decode: assert property (
        ce && sw_wr |=> dec_valid && s_reg.opword == $past(hwdata[15:0])
    ) else $error("software word not decoded");
endmodule
`default_nettype wire

//--- src/ald_defines.svh
`ifndef ALD_DEFINES_SVH
`define ALD_DEFINES_SVH
// register byte offsets
`define ALD_OFS_CTRL 8'h00
`define ALD_OFS_OPWORD 8'h04
`define ALD_OFS_RESULT 8'h08
`define ALD_OFS_IMMED 8'h0c
// control register fields and reset values
`define ALD_CTRL_PORT_EN_BIT 0
`define ALD_CTRL_PORT_EN_RST 1'b1
`define ALD_OPWORD_RST 16'h0000
// instruction line codes in bits 15..12
`define ALD_LINE_QUICK 4'h7
`define ALD_LINE_OR 4'h8
`define ALD_LINE_SUB 4'h9
`define ALD_LINE_CMP 4'hb
`define ALD_LINE_AND 4'hc
`define ALD_LINE_ADD 4'hd
// opmode codes
`define ALD_OPM_ADDR 2'h3
`define ALD_OPM_LONG_BIT 2
// bits 8..4 pattern of the decimal forms
`define ALD_DECIMAL_PAT 5'h10
// exchange types in bits 7..3
`define ALD_SWAP_DATA 5'h08
`define ALD_SWAP_ADDR 5'h09
`define ALD_SWAP_MIXED 5'h11
`endif

//--- src/ald_pkg.sv
package ald_pkg;
    // decoded operation
    typedef enum logic [4:0] {
        op_none, op_quick_immediate_load, op_or, op_and, op_exclusive_or,
        op_add, op_sub, op_address_add, op_address_subtract, op_cmp,
        op_address_cmp, op_add_with_extend, op_subtract_with_extend,
        op_memory_compare_postinc, op_decimal_add, op_decimal_subtract,
        op_register_swap
    } ald_op_t;
    // operand size
    typedef enum logic [1:0] {sz_byte, sz_word, sz_long, sz_none} ald_size_t;
    // decoded fields, also the readable result word
    typedef struct packed {
        logic legal;
        ald_op_t op;
        ald_size_t size;
        logic ea_dest;
        logic flags_only;
        logic mem_mode;
        logic predec;
        logic postinc;
        logic rx_addr;
        logic ry_addr;
        logic [2:0] rx;
        logic [2:0] ry;
    } ald_res_t;
    // full decode with immediate
    typedef struct packed {
        ald_res_t res;
        logic [31:0] imm;
    } ald_dec_t;
    // all state of the top module
    typedef struct packed {
        logic pend;
        logic pwrite;
        logic [7:0] paddr;
        logic port_en;
        logic [15:0] opword;
        ald_dec_t dec;
        logic dec_valid;
        logic [31:0] hrdata;
    } ald_state_t;
endpackage

//--- src/ald_field_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "ald_defines.svh"
module ald_field_decode (
    input wire logic [15:0] word,
    output ald_pkg::ald_dec_t dec
);
    logic [3:0] line; // instruction line
    logic [2:0] opm; // opmode field
    logic [4:0] xtype; // exchange type
    assign line = word[15:12];
    assign opm = word[8:6];
    assign xtype = word[7:3];

    // two-bit size field to size
    function automatic ald_pkg::ald_size_t size_of(input logic [1:0] f);
        case (f)
            2'h0: size_of = ald_pkg::sz_byte;
            2'h1: size_of = ald_pkg::sz_word;
            2'h2: size_of = ald_pkg::sz_long;
            default: size_of = ald_pkg::sz_none;
        endcase
    endfunction

    // pure combinational decode of one word
    always_comb begin
        dec = '0;
        dec.res.size = ald_pkg::sz_none;
        dec.res.rx = word[11:9];
        dec.res.ry = word[2:0];
        case (line)
            `ALD_LINE_QUICK: begin
                if (!word[8]) begin
                    dec.res.legal = 1'b1;
                    dec.res.op = ald_pkg::op_quick_immediate_load;
                    dec.res.size = ald_pkg::sz_long;
                    dec.imm = {{24{word[7]}}, word[7:0]};
                end
            end
            `ALD_LINE_OR, `ALD_LINE_AND: begin
                if (word[8:4] == `ALD_DECIMAL_PAT) begin
                    dec.res.legal = 1'b1;
                    dec.res.op = (line == `ALD_LINE_OR) ? ald_pkg::op_decimal_subtract : ald_pkg::op_decimal_add;
                    dec.res.size = ald_pkg::sz_byte;
                    dec.res.mem_mode = word[3];
                    dec.res.predec = word[3];
                    dec.res.rx_addr = word[3];
                    dec.res.ry_addr = word[3];
                end else if (line == `ALD_LINE_AND && word[8] && (xtype == `ALD_SWAP_DATA ||
                             xtype == `ALD_SWAP_ADDR || xtype == `ALD_SWAP_MIXED)) begin
                    dec.res.legal = 1'b1;
                    dec.res.op = ald_pkg::op_register_swap;
                    dec.res.size = ald_pkg::sz_long;
                    dec.res.rx_addr = (xtype == `ALD_SWAP_ADDR);
                    dec.res.ry_addr = (xtype != `ALD_SWAP_DATA);
                end else if (opm[1:0] != `ALD_OPM_ADDR) begin
                    dec.res.legal = 1'b1;
                    dec.res.op = (line == `ALD_LINE_OR) ? ald_pkg::op_or : ald_pkg::op_and;
                    dec.res.size = size_of(opm[1:0]);
                    dec.res.ea_dest = opm[`ALD_OPM_LONG_BIT];
                end
            end
            `ALD_LINE_SUB, `ALD_LINE_ADD: begin
                dec.res.legal = 1'b1;
                if (opm[1:0] == `ALD_OPM_ADDR) begin
                    dec.res.op = (line == `ALD_LINE_SUB) ? ald_pkg::op_address_subtract : ald_pkg::op_address_add;
                    dec.res.size = opm[`ALD_OPM_LONG_BIT] ? ald_pkg::sz_long : ald_pkg::sz_word;
                    dec.res.rx_addr = 1'b1;
                end else if (word[8] && word[5:4] == 2'h0) begin
                    dec.res.op = (line == `ALD_LINE_SUB) ? ald_pkg::op_subtract_with_extend
                        : ald_pkg::op_add_with_extend;
                    dec.res.size = size_of(word[7:6]);
                    dec.res.mem_mode = word[3];
                    dec.res.predec = word[3];
                    dec.res.rx_addr = word[3];
                    dec.res.ry_addr = word[3];
                end else begin
                    dec.res.op = (line == `ALD_LINE_SUB) ? ald_pkg::op_sub : ald_pkg::op_add;
                    dec.res.size = size_of(opm[1:0]);
                    dec.res.ea_dest = opm[`ALD_OPM_LONG_BIT];
                end
            end
            `ALD_LINE_CMP: begin
                dec.res.legal = 1'b1;
                dec.res.flags_only = 1'b1;
                if (opm[1:0] == `ALD_OPM_ADDR) begin
                    dec.res.op = ald_pkg::op_address_cmp;
                    dec.res.size = opm[`ALD_OPM_LONG_BIT] ? ald_pkg::sz_long : ald_pkg::sz_word;
                    dec.res.rx_addr = 1'b1;
                end else if (!word[8]) begin
                    dec.res.op = ald_pkg::op_cmp;
                    dec.res.size = size_of(opm[1:0]);
                end else if (word[5:3] == 3'h1) begin
                    dec.res.op = ald_pkg::op_memory_compare_postinc;
                    dec.res.size = size_of(word[7:6]);
                    dec.res.mem_mode = 1'b1;
                    dec.res.postinc = 1'b1;
                    dec.res.rx_addr = 1'b1;
                    dec.res.ry_addr = 1'b1;
                end else begin
                    dec.res.op = ald_pkg::op_exclusive_or;
                    dec.res.flags_only = 1'b0;
                    dec.res.size = size_of(opm[1:0]);
                    dec.res.ea_dest = 1'b1;
                end
            end
            default: begin
                dec.res.legal = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- tb/ald_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// prefetch queue standing in front of the decoder
module ald_fetch_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [15:0] fetch_word
);
    logic [15:0] q[$]; // words waiting to be offered
    // queue one word from the bench
    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask
    // offer a word and hold it until taken; idle one cycle between words when slow
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_valid <= 1'b0;
            fetch_word <= 16'h0000;
        end else if (!fetch_valid || fetch_ready) begin
            if (q.size() > 0 && !(slow && fetch_valid)) begin
                fetch_valid <= 1'b1;
                fetch_word <= q.pop_front();
            end else begin
                // nothing offered: word lines keep moving so no stale value looks valid
                fetch_valid <= 1'b0;
                fetch_word <= ~fetch_word;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/arith_logic_opcode_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module arith_logic_opcode_decoder_tb;
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, slow; // bus and control
    logic [31:0] haddr, hwdata, hrdata, rd; // rd holds the last read word
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic fetch_valid, fetch_ready, dec_valid;
    logic [15:0] fetch_word;
    ald_pkg::ald_dec_t dec;
    ald_pkg::ald_res_t er; // result word after reset
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] qv[4] = '{8'h00, 8'h7f, 8'h80, 8'hff}; // immediates at sign boundaries
    logic [3:0] ln[4] = '{4'h8, 4'h9, 4'hc, 4'hd}; // lines with both directions
    ald_pkg::ald_op_t lop[4] = '{ald_pkg::op_or, ald_pkg::op_sub, ald_pkg::op_and, ald_pkg::op_add};
    logic [3:0] aln[3] = '{4'h9, 4'hb, 4'hd}; // lines with address forms
    ald_pkg::ald_op_t aop[3] = '{ald_pkg::op_address_subtract, ald_pkg::op_address_cmp, ald_pkg::op_address_add};
    logic [4:0] swt[3] = '{5'h08, 5'h09, 5'h11}; // swap types
    logic rxa[3] = '{1'b0, 1'b1, 1'b0};
    logic rya[3] = '{1'b0, 1'b1, 1'b1};
    // 50 ns clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    ald_top u_ald_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec(dec));
    ald_fetch_model u_ald_fetch_model (.hclk(hclk), .hresetn(hresetn), .slow(slow), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word));
    // verdict and end of run
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single-word bus transfer, read data left in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask
    // wait for the next decode pulse, bounded
    task automatic wait_dec();
        @(negedge hclk);
        for (int i = 0; i < 20 && dec_valid !== 1'b1; i++) @(negedge hclk);
        chk("dec_valid", 1, dec_valid);
    endtask
    // offer a word on the prefetch port and wait for its decode
    task automatic feed(input logic [15:0] w);
        u_ald_fetch_model.push(w);
        wait_dec();
    endtask
    // opmode forms: operation, size, direction, flags only, upper register field
    task automatic exp_alu(input logic [15:0] w, input ald_pkg::ald_op_t op, input ald_pkg::ald_size_t sz,
        input logic ea, input logic fl);
        feed(w);
        chk("alu", {1'b1, op, sz, ea, fl, w[11:9]}, {dec.res.legal, dec.res.op, dec.res.size,
            dec.res.ea_dest, dec.res.flags_only, dec.res.rx});
    endtask
    // extended, decimal and memory compare forms: operand space and register kinds
    task automatic exp_ext(input logic [15:0] w, input ald_pkg::ald_op_t op, input logic mem, input logic pre);
        feed(w);
        chk("ext", {1'b1, op, mem, pre, mem & ~pre, mem, mem, w[11:9], w[2:0]}, {dec.res.legal, dec.res.op,
            dec.res.mem_mode, dec.res.predec, dec.res.postinc, dec.res.rx_addr, dec.res.ry_addr, dec.res.rx,
            dec.res.ry});
    endtask
    // reset values, unmapped place ignored
    task automatic t_reset_values();
        ahb(1'b1, 8'h10, 32'hffffffff);
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 0, rd);
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 1, rd);
        ahb(1'b0, 8'h08, 32'h0);
        chk("result", {11'h0, er}, rd);
    endtask
    // software decode of a negative immediate
    task automatic t_sw_decode();
        ahb(1'b1, 8'h04, 32'h00007a80);
        wait_dec();
        chk("qop", ald_pkg::op_quick_immediate_load, dec.res.op);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("immed", 32'hffffff80, rd);
        ahb(1'b0, 8'h04, 32'h0);
        chk("opword", 32'h7a80, rd);
        ahb(1'b0, 8'h08, 32'h0);
        chk("result", 32'h0010c028, rd);
    endtask
    // back to back words on the prefetch port
    task automatic t_prefetch_burst();
        @(negedge hclk);
        for (int i = 0; i < 4; i++) u_ald_fetch_model.push({4'h7, 3'h3, 1'b0, qv[i]});
        for (int i = 0; i < 4; i++) begin
            wait_dec();
            chk("imm", {{24{qv[i][7]}}, qv[i]}, dec.imm);
        end
    endtask
    // every size and direction of the opmode forms
    task automatic t_opmodes();
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 2; d++) begin
                for (int k = 0; k < 4; k++)
                    exp_alu({ln[k], 3'h5, d[0], s[1:0], 6'h12}, lop[k], ald_pkg::ald_size_t'(s[1:0]), d[0],
                        1'b0);
                exp_alu({4'hb, 3'h5, d[0], s[1:0], 6'h12}, d[0] ? ald_pkg::op_exclusive_or : ald_pkg::op_cmp,
                    ald_pkg::ald_size_t'(s[1:0]), d[0], ~d[0]);
            end
        end
        for (int k = 0; k < 3; k++) begin
            for (int l = 0; l < 2; l++)
                exp_alu({aln[k], 3'h3, l[0], 2'b11, 6'h12}, aop[k], l[0] ? ald_pkg::sz_long : ald_pkg::sz_word,
                    1'b0, k == 1);
        end
    endtask
    // operand space of the extended and decimal forms, with sizes
    task automatic t_ext_forms();
        for (int m = 0; m < 2; m++) begin
            exp_ext({4'h8, 3'h6, 5'h10, m[0], 3'h1}, ald_pkg::op_decimal_subtract, m[0], m[0]);
            exp_ext({4'hc, 3'h6, 5'h10, m[0], 3'h1}, ald_pkg::op_decimal_add, m[0], m[0]);
            for (int s = 0; s < 3; s++) begin
                exp_ext({4'h9, 3'h4, 1'b1, s[1:0], 2'b00, m[0], 3'h7}, ald_pkg::op_subtract_with_extend, m[0],
                    m[0]);
                chk("size", s, dec.res.size);
                exp_ext({4'hd, 3'h4, 1'b1, s[1:0], 2'b00, m[0], 3'h7}, ald_pkg::op_add_with_extend, m[0],
                    m[0]);
                chk("size", s, dec.res.size);
                exp_ext({4'hb, 3'h4, 1'b1, s[1:0], 3'b001, 3'h7}, ald_pkg::op_memory_compare_postinc, 1'b1, 1'b0);
                chk("size", s, dec.res.size);
            end
        end
    endtask
    // slow source: swap types and unlisted codes
    task automatic t_swap_unlisted();
        slow <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            feed({4'hc, 3'h2, 1'b1, swt[k], 3'h5});
            chk("swap", {1'b1, ald_pkg::op_register_swap, rxa[k], rya[k], 6'o25}, {dec.res.legal, dec.res.op,
                dec.res.rx_addr, dec.res.ry_addr, dec.res.rx, dec.res.ry});
        end
        feed({4'h8, 3'h1, 3'b011, 6'h12});
        chk("legal", 0, dec.res.legal);
        feed({4'hc, 3'h1, 3'b111, 6'h12});
        chk("legal", 0, dec.res.legal);
        feed({4'hc, 3'h1, 1'b1, 5'h0a, 3'h5});
        chk("op", ald_pkg::op_and, dec.res.op);
        feed(16'h7180);
        chk("legal", {1'b0, ald_pkg::op_none}, {dec.res.legal, dec.res.op});
    endtask
    // port disabled by software, then clock enable low
    task automatic t_port_gate();
        ahb(1'b1, 8'h00, 32'h0);
        @(negedge hclk);
        u_ald_fetch_model.push(16'h7c01);
        repeat (3) @(negedge hclk);
        chk("gated", 0, {fetch_ready, dec_valid});
        ahb(1'b1, 8'h00, 32'h1);
        wait_dec();
        chk("imm", 1, dec.imm);
        @(posedge hclk);
        ce <= 1'b0;
        @(negedge hclk);
        u_ald_fetch_model.push(16'h7cfe);
        repeat (2) @(negedge hclk);
        chk("stall", 0, {hreadyout, fetch_ready, dec_valid});
        @(posedge hclk);
        ce <= 1'b1;
        wait_dec();
        chk("imm", 32'hfffffffe, dec.imm);
    endtask
    // main sequence: reset, then every scenario in turn
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        slow = 1'b0;
        er = '0;
        er.size = ald_pkg::sz_none;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_sw_decode();
        t_prefetch_burst();
        t_opmodes();
        t_ext_forms();
        t_swap_unlisted();
        t_port_gate();
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
